// *** rtl/medc_detect.sv ***
`timescale 1ns/100ps
// What this block does
// - Four-way mode ignores Z orientation
// - Angle threshold selects 80/70/60/50 degrees
// - Z tap threshold, LSB full scale/32
// - Double tap gap: 0 is 16, else x32
// - Quiet window: 0 is 2, else x4
// - Shock limit: 0 is 4, else x8
// - Double-tap enable adds double-tap events
// - Offset source picks low-pass wake data
// - Wake level 6 bits, weight /64 or /256
// - Wake persist count in sample periods
// - Sleep delay: 0 is 16, else x512
// - Free-fall length: msb plus five bits
// - Free-fall level table 156..500 mg
// - Routing bits gate events onto pin one
// - Basic events need global enable bit
module medc_detect (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [medc_pkg::ADDR_W-1:2] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   input wire logic sample_stb,
   input wire medc_pkg::medc_sample_s sample,
   input wire logic emb_func_evt,
   input wire logic shub_done_evt,
   output logic irq_pin_one,
   output logic irq_o,
   output logic sleep_state
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Window length: zero code gives a base, else code times a power of 2
   function automatic logic [15:0] win_len(input logic [3:0] code,
                                           input logic [15:0] base,
                                           input int shift);
      logic [15:0] w;
      w = 16'({12'h000, code} << shift);
      return (code == 4'h0) ? base : w;
   endfunction

   // Tilt magnitude limit per angle code, full scale 255 as 1 g
   function automatic medc_pkg::medc_level_t angle_lvl(input logic [1:0] c);
      case (c)
         2'b00: return 8'hFB; // 80 degrees
         2'b01: return 8'hF0; // 70 degrees
         2'b10: return 8'hDD; // 60 degrees
         default: return 8'hC3; // 50 degrees
      endcase
   endfunction

   // Free-fall limit per code, 256 as 1 g
   function automatic medc_pkg::medc_level_t ff_lvl(input logic [2:0] c);
      case (c)
         3'b000: return 8'h28; // 156 mg
         3'b001: return 8'h38; // 219 mg
         3'b010: return 8'h40; // 250 mg
         3'b011: return 8'h50; // 312 mg
         3'b100: return 8'h58; // 344 mg
         3'b101: return 8'h68; // 406 mg
         3'b110: return 8'h78; // 469 mg
         default: return 8'h80; // 500 mg
      endcase
   endfunction

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [7:0] orient_tap_r, tap_win_r, wake_ths_r, wakeup_persist_count_r;
   logic [7:0] freefall_r, route1_r, evt_status_r, evt_enable_r;
   logic basic_en_r;
   logic [7:0] evt_set;
   logic [7:0] evt_clr;
   logic wr_stb;
   logic [7:0] idx;
   logic [7:0] wdat;

   assign idx = 8'(wb_adr_i);
   assign wdat = wb_dat_i[7:0];
   assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
                   && wb_sel_i[0];
   assign evt_clr = (wr_stb && idx == medc_pkg::IDX_EVT_CLEAR) ? wdat
                    : 8'h00;

   // Configuration writes; only byte lane 0 carries data
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         orient_tap_r <= medc_pkg::REG_RESET;
         tap_win_r <= medc_pkg::REG_RESET;
         wake_ths_r <= medc_pkg::REG_RESET;
         wakeup_persist_count_r <= medc_pkg::REG_RESET;
         freefall_r <= medc_pkg::REG_RESET;
         route1_r <= medc_pkg::REG_RESET;
         evt_enable_r <= medc_pkg::REG_RESET;
         basic_en_r <= 1'b0;
      end else if (wr_stb) begin
         case (idx)
            medc_pkg::IDX_ORIENT_TAP: orient_tap_r <= wdat;
            medc_pkg::IDX_TAP_WIN: tap_win_r <= wdat;
            medc_pkg::IDX_WAKE_THS: wake_ths_r <= wdat;
            medc_pkg::IDX_WAKEUP_PERSIST_COUNT: wakeup_persist_count_r <= wdat;
            medc_pkg::IDX_FREEFALL: freefall_r <= wdat;
            medc_pkg::IDX_ROUTE1: route1_r <= wdat;
            medc_pkg::IDX_EVT_ENABLE: evt_enable_r <= wdat;
            medc_pkg::IDX_BASIC_CTRL: basic_en_r <= wdat[0];
            default: ;
         endcase
      end
   end

   // Read mux; unmapped words read zero but are still acked
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         case (idx)
            medc_pkg::IDX_ORIENT_TAP: wb_dat_o <= {24'h00_0000, orient_tap_r};
            medc_pkg::IDX_TAP_WIN: wb_dat_o <= {24'h00_0000, tap_win_r};
            medc_pkg::IDX_WAKE_THS: wb_dat_o <= {24'h00_0000, wake_ths_r};
            medc_pkg::IDX_WAKEUP_PERSIST_COUNT: wb_dat_o <= {24'h00_0000, wakeup_persist_count_r};
            medc_pkg::IDX_FREEFALL: wb_dat_o <= {24'h00_0000, freefall_r};
            medc_pkg::IDX_ROUTE1: wb_dat_o <= {24'h00_0000, route1_r};
            medc_pkg::IDX_EVT_STATUS: wb_dat_o <= {24'h00_0000, evt_status_r};
            medc_pkg::IDX_EVT_ENABLE: wb_dat_o <= {24'h00_0000, evt_enable_r};
            medc_pkg::IDX_BASIC_CTRL: wb_dat_o <= {31'h0000_0000, basic_en_r};
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // ****************************************************************
   // Field decode
   // ****************************************************************
   logic four_way_orientation_mode;
   logic [1:0] orientation_angle_threshold;
   logic [4:0] tap_threshold_z;
   logic [3:0] double_tap_gap_limit;
   logic [1:0] quiet_code, shock_code;
   logic double_tap_en, wakeup_offset_source, wakeup_level_weight;
   logic [5:0] wakeup_level;
   logic [1:0] wakeup_persist_count;
   logic [3:0] sleep_entry_delay;
   logic [5:0] freefall_len;
   logic [2:0] freefall_level;
   logic [15:0] gap_len, quiet_len, shock_len, sleep_len;
   logic [7:0] tap_lvl, wake_lvl, wake_mag;

   assign four_way_orientation_mode = orient_tap_r[7];
   assign orientation_angle_threshold = orient_tap_r[6:5];
   assign tap_threshold_z = orient_tap_r[4:0];
   assign double_tap_gap_limit = tap_win_r[7:4];
   assign quiet_code = tap_win_r[3:2];
   assign shock_code = tap_win_r[1:0];
   assign double_tap_en = wake_ths_r[7];
   assign wakeup_offset_source = wake_ths_r[6];
   assign wakeup_level = wake_ths_r[5:0];
   assign freefall_len = {wakeup_persist_count_r[7], freefall_r[7:3]};
   assign wakeup_persist_count = wakeup_persist_count_r[6:5];
   assign wakeup_level_weight = wakeup_persist_count_r[4];
   assign sleep_entry_delay = wakeup_persist_count_r[3:0];
   assign freefall_level = freefall_r[2:0];
   assign gap_len = win_len(double_tap_gap_limit, medc_pkg::GAP_ZERO,
                            medc_pkg::GAP_SHIFT);
   assign quiet_len = win_len({2'b00, quiet_code}, medc_pkg::QUIET_ZERO,
                              medc_pkg::QUIET_SHIFT);
   assign shock_len = win_len({2'b00, shock_code}, medc_pkg::SHOCK_ZERO,
                              medc_pkg::SHOCK_SHIFT);
   assign sleep_len = win_len(sleep_entry_delay, medc_pkg::SLEEP_ZERO,
                              medc_pkg::SLEEP_SHIFT);
   // 8-bit magnitude: full scale 256, so /32 is shift 3
   assign tap_lvl = {tap_threshold_z, 3'b000};
   // Weight /64 is shift 2, /256 is shift 0
   assign wake_lvl = wakeup_level_weight ? {2'b00, wakeup_level}
                     : {wakeup_level, 2'b00};
   assign wake_mag = wakeup_offset_source ? sample.wake_lp_mag
                     : sample.wake_hp_mag;

   // ****************************************************************
   // Tap state machine, ticks on samples only
   // ****************************************************************
   typedef enum logic [3:0] {
      TAP_IDLE = 4'b0001,
      TAP_SHOCK = 4'b0010,
      TAP_QUIET = 4'b0100,
      TAP_GAP = 4'b1000
   } medc_tap_e;
   medc_tap_e tap_st_r;
   logic [15:0] tap_cnt_r;
   logic tap_over, first_done_r, stap_evt, dtap_evt;
   assign tap_over = sample.tap_z_mag > tap_lvl;

   // Shock, quiet, optional gap; overlong pulse waits out its end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tap_st_r <= TAP_IDLE;
         tap_cnt_r <= 16'h0000;
         first_done_r <= 1'b0;
         stap_evt <= 1'b0;
         dtap_evt <= 1'b0;
      end else begin
         stap_evt <= 1'b0;
         dtap_evt <= 1'b0;
         if (sample_stb) begin
            case (tap_st_r)
               TAP_IDLE: begin
                  tap_cnt_r <= 16'h0001;
                  if (tap_over) tap_st_r <= TAP_SHOCK;
               end
               TAP_SHOCK: begin
                  if (!tap_over) begin
                     tap_st_r <= tap_cnt_r > shock_len ? TAP_IDLE : TAP_QUIET;
                     tap_cnt_r <= 16'h0001;
                  end else if (tap_cnt_r >= shock_len) begin
                     tap_cnt_r <= shock_len + 16'h0001;
                     first_done_r <= 1'b0;
                  end else begin
                     tap_cnt_r <= tap_cnt_r + 16'h0001;
                  end
               end
               TAP_QUIET: begin
                  if (tap_over) begin
                     tap_st_r <= TAP_IDLE;
                     first_done_r <= 1'b0;
                  end else if (tap_cnt_r >= quiet_len) begin
                     tap_cnt_r <= 16'h0001;
                     if (first_done_r) begin
                        dtap_evt <= 1'b1;
                        first_done_r <= 1'b0;
                        tap_st_r <= TAP_IDLE;
                     end else if (double_tap_en) begin
                        stap_evt <= 1'b1;
                        first_done_r <= 1'b1;
                        tap_st_r <= TAP_GAP;
                     end else begin
                        stap_evt <= 1'b1;
                        tap_st_r <= TAP_IDLE;
                     end
                  end else begin
                     tap_cnt_r <= tap_cnt_r + 16'h0001;
                  end
               end
               TAP_GAP: begin
                  if (tap_over) begin
                     tap_st_r <= TAP_SHOCK;
                     tap_cnt_r <= 16'h0001;
                  end else if (tap_cnt_r >= gap_len) begin
                     tap_st_r <= TAP_IDLE;
                     first_done_r <= 1'b0;
                  end else begin
                     tap_cnt_r <= tap_cnt_r + 16'h0001;
                  end
               end
               default: tap_st_r <= TAP_IDLE;
            endcase
         end
      end
   end

   // ****************************************************************
   // Wake-up, sleep and free-fall counters
   // ****************************************************************
   logic [2:0] wake_cnt_r;
   logic [15:0] inact_cnt_r;
   logic [6:0] ff_cnt_r;
   logic wake_hit, wu_evt, ff_evt, sleep_evt, ff_low;
   assign wake_hit = wake_mag > wake_lvl;
   assign ff_low = sample.total_mag < ff_lvl(freefall_level);

   // Wake needs persist+1 consecutive samples above level
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wake_cnt_r <= 3'b000;
         wu_evt <= 1'b0;
      end else begin
         wu_evt <= 1'b0;
         if (sample_stb) begin
            if (!wake_hit) begin
               wake_cnt_r <= 3'b000;
            end else if (wake_cnt_r == {1'b0, wakeup_persist_count}) begin
               wu_evt <= 1'b1;
               wake_cnt_r <= wake_cnt_r + 3'b001;
            end else if (wake_cnt_r <= {1'b0, wakeup_persist_count}) begin
               wake_cnt_r <= wake_cnt_r + 3'b001;
            end
         end
      end
   end

   // Inactivity toward sleep; any wake sample leaves sleep
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         inact_cnt_r <= 16'h0000;
         sleep_state <= 1'b0;
         sleep_evt <= 1'b0;
      end else begin
         sleep_evt <= 1'b0;
         if (sample_stb) begin
            if (wake_hit) begin
               inact_cnt_r <= 16'h0000;
               sleep_evt <= sleep_state;
               sleep_state <= 1'b0;
            end else if (!sleep_state) begin
               if (inact_cnt_r + 16'h0001 >= sleep_len) begin
                  sleep_state <= 1'b1;
                  sleep_evt <= 1'b1;
               end else begin
                  inact_cnt_r <= inact_cnt_r + 16'h0001;
               end
            end
         end
      end
   end

   // Free-fall needs length+1 consecutive low samples
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ff_cnt_r <= 7'h00;
         ff_evt <= 1'b0;
      end else begin
         ff_evt <= 1'b0;
         if (sample_stb) begin
            if (!ff_low) begin
               ff_cnt_r <= 7'h00;
            end else if (ff_cnt_r == {1'b0, freefall_len}) begin
               ff_evt <= 1'b1;
               ff_cnt_r <= ff_cnt_r + 7'h01;
            end else if (ff_cnt_r < {1'b0, freefall_len}) begin
               ff_cnt_r <= ff_cnt_r + 7'h01;
            end
         end
      end
   end

   // ****************************************************************
   // Orientation
   // ****************************************************************
   logic [5:0] pos_r, pos_now;
   logic o6d_evt;
   logic [7:0] alvl;
   assign alvl = angle_lvl(orientation_angle_threshold);
   // Bits: x+, x-, y+, y-, z+, z- from signed tilt values
   assign pos_now = {
      !sample.tilt_x[7] && (sample.tilt_x > (alvl >> 1)),
      sample.tilt_x[7] && ((8'h00 - sample.tilt_x) > (alvl >> 1)),
      !sample.tilt_y[7] && (sample.tilt_y > (alvl >> 1)),
      sample.tilt_y[7] && ((8'h00 - sample.tilt_y) > (alvl >> 1)),
      !four_way_orientation_mode && !sample.tilt_z[7]
         && (sample.tilt_z > (alvl >> 1)),
      !four_way_orientation_mode && sample.tilt_z[7]
         && ((8'h00 - sample.tilt_z) > (alvl >> 1))};

   // Event on change of position
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pos_r <= 6'h00;
         o6d_evt <= 1'b0;
      end else begin
         o6d_evt <= sample_stb && (pos_now != pos_r);
         if (sample_stb) pos_r <= pos_now;
      end
   end

   // ****************************************************************
   // Status, interrupt and pin routing
   // ****************************************************************
   // Basic events gated by global enable; external ones pass
   assign evt_set = {sleep_evt, stap_evt, wu_evt, ff_evt, dtap_evt,
                     o6d_evt, 2'b00} & {{6{basic_en_r}}, 2'b11}
                    | {6'h00, emb_func_evt, shub_done_evt};

   // Set wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) evt_status_r <= 8'h00;
      else evt_status_r <= (evt_status_r & ~evt_clr) | evt_set;
   end

   // Level outputs from flip-flops
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_o <= 1'b0;
         irq_pin_one <= 1'b0;
      end else begin
         irq_o <= |(((evt_status_r & ~evt_clr) | evt_set) & evt_enable_r);
         irq_pin_one <= |(((evt_status_r & ~evt_clr) | evt_set)
                          & route1_r);
      end
   end
endmodule // medc_detect

// *** rtl/medc_pkg.sv ***
package medc_pkg;
   // ****************************************************************
   // Register word addresses (printed offsets are not multiples of 4)
   // ****************************************************************
   localparam logic [7:0] IDX_ORIENT_TAP = 8'h59;
   localparam logic [7:0] IDX_TAP_WIN = 8'h5A;
   localparam logic [7:0] IDX_WAKE_THS = 8'h5B;
   localparam logic [7:0] IDX_WAKEUP_PERSIST_COUNT = 8'h5C;
   localparam logic [7:0] IDX_FREEFALL = 8'h5D;
   localparam logic [7:0] IDX_ROUTE1 = 8'h5E;
   localparam logic [7:0] IDX_BASIC_CTRL = 8'h60;
   localparam logic [7:0] IDX_EVT_STATUS = 8'h61;
   localparam logic [7:0] IDX_EVT_CLEAR = 8'h62;
   localparam logic [7:0] IDX_EVT_ENABLE = 8'h63;
   localparam int ADDR_W = 10;

   // ****************************************************************
   // Timing multipliers, in sample periods
   // ****************************************************************
   localparam logic [15:0] GAP_ZERO = 16'h0010;
   localparam int GAP_SHIFT = 5;
   localparam logic [15:0] QUIET_ZERO = 16'h0002;
   localparam int QUIET_SHIFT = 2;
   localparam logic [15:0] SHOCK_ZERO = 16'h0004;
   localparam int SHOCK_SHIFT = 3;
   localparam logic [15:0] SLEEP_ZERO = 16'h0010;
   localparam int SLEEP_SHIFT = 9;
   localparam logic [7:0] REG_RESET = 8'h00;

   // Event bit positions, same layout as the routing register
   localparam int EV_SLEEP = 7;
   localparam int EV_STAP = 6;
   localparam int EV_WU = 5;
   localparam int EV_FF = 4;
   localparam int EV_DTAP = 3;
   localparam int EV_6D = 2;
   localparam int EV_EMB = 1;
   localparam int EV_SHUB = 0;

   // Magnitudes from the sensing path, per sample
   typedef struct packed {
      logic [7:0] tap_z_mag;
      logic [7:0] wake_hp_mag;
      logic [7:0] wake_lp_mag;
      logic [7:0] total_mag;
      logic [7:0] tilt_x;
      logic [7:0] tilt_y;
      logic [7:0] tilt_z;
   } medc_sample_s;

   // Magnitude codes for the tilt angle and free-fall tables
   typedef logic [7:0] medc_level_t;
endpackage

// *** tb/medc_detect_props.sv ***
`timescale 1ns/100ps
module medc_detect_props (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [medc_pkg::ADDR_W-1:2] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic emb_func_evt,
   input wire logic irq_pin_one,
   input wire logic irq_o,
   input wire logic sleep_state
);
   // ****************
   // Shadow registers
   // ****************
   logic [7:0] en_r;
   logic [7:0] route_r;
   logic ctrl_r;
   logic wr_hit;
   logic rd_zero;
   assign wr_hit = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & wb_ack_o;
   // Clear index reads zero like unmapped space
   assign rd_zero = !(wb_adr_i inside {[medc_pkg::IDX_ORIENT_TAP:
      medc_pkg::IDX_ROUTE1], medc_pkg::IDX_BASIC_CTRL,
      medc_pkg::IDX_EVT_STATUS, medc_pkg::IDX_EVT_ENABLE});
   // Shadows follow writes at the ack edge only
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         en_r <= 8'h00;
         route_r <= 8'h00;
         ctrl_r <= 1'b0;
      end else if (wr_hit) begin
         if (wb_adr_i == medc_pkg::IDX_EVT_ENABLE) en_r <= wb_dat_i[7:0];
         if (wb_adr_i == medc_pkg::IDX_ROUTE1) route_r <= wb_dat_i[7:0];
         if (wb_adr_i == medc_pkg::IDX_BASIC_CTRL) ctrl_r <= wb_dat_i[0];
      end
   end
   // ****************
   // Properties
   // ****************
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_after_take: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered next cycle");
   a_ack_needs_req: assert property (
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
      else $error("ack without request");
   a_rdata_byte_only: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_unmapped_reads_zero: assert property (
      wb_ack_o && !wb_we_i && rd_zero |-> wb_dat_o == 32'h0000_0000)
      else $error("unmapped index read nonzero");
   a_irq_mask_gate: assert property ($rose(irq_o) |-> en_r != 8'h00)
      else $error("irq rose with enable clear");
   a_pin_route_gate: assert property (
      $rose(irq_pin_one) |-> route_r != 8'h00)
      else $error("pin rose with routing clear");
   a_emb_route_path: assert property (
      emb_func_evt && route_r[1] |-> ##[1:3] irq_pin_one)
      else $error("routed event missed pin");
   a_sleep_global_gate: assert property (
      $rose(sleep_state) && ctrl_r && en_r[7] |-> ##[1:3] irq_o)
      else $error("enabled sleep change missed irq");
   a_reset_quiet: assert property (@(posedge clk) disable iff (1'b0)
      !rst_b ##1 !rst_b |-> !wb_ack_o && !irq_o && !irq_pin_one
      && !sleep_state)
      else $error("outputs active in reset");
endmodule // medc_detect_props

bind medc_detect medc_detect_props i_props (.clk(clk), .rst_b(rst_b),
   .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .emb_func_evt(emb_func_evt),
   .irq_pin_one(irq_pin_one), .irq_o(irq_o), .sleep_state(sleep_state));

// *** tb/medc_host.sv ***
`timescale 1ns/100ps
module medc_host (
   input wire logic clk,
   input wire logic wb_ack_o,
   output logic [medc_pkg::ADDR_W-1:2] wb_adr_i,
   output logic [31:0] wb_dat_i,
   output logic wb_we_i,
   output logic [3:0] wb_sel_i,
   output logic wb_cyc_i,
   output logic wb_stb_i
);
   // Idle bus; data inverted so a stale value never looks valid
   initial begin
      wb_adr_i = 8'h00;
      wb_dat_i = 32'hffff_ffff;
      wb_we_i = 1'b0;
      wb_sel_i = 4'h0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
   end
   // One classic cycle; the leading edge keeps cyc low a cycle
   task automatic xfer(input logic [7:0] a, input logic w,
                       input logic [7:0] d);
      @(posedge clk);
      wb_adr_i <= a;
      wb_we_i <= w;
      wb_dat_i <= {24'h00_0000, d};
      wb_sel_i <= 4'hf;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      do @(posedge clk); while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      wb_dat_i <= ~{24'h00_0000, d};
   endtask
endmodule // medc_host

// *** tb/medc_detect_bench.sv ***
`timescale 1ns/100ps
module medc_detect_bench;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [medc_pkg::ADDR_W-1:2] wb_adr_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
   logic [3:0] wb_sel_i;
   logic sample_stb = 1'b0;
   medc_pkg::medc_sample_s sample = '0;
   logic emb_func_evt = 1'b0;
   logic shub_done_evt = 1'b0;
   logic irq_pin_one, irq_o, sleep_state;
   logic [2:0] outs;
   assign outs = {sleep_state, irq_pin_one, irq_o};
   logic [31:0] exp_q[$];
   int err_count = 0;
   int cmp_count = 0;
   int cyc_n = 0;
   int seed = 32'h75ff0923;
   logic [7:0] d;
   logic [7:0] rst_idx[9] = '{8'h59, 8'h5A, 8'h5B, 8'h5C, 8'h5D, 8'h5E,
      8'h60, 8'h61, 8'h63};
   always #10 clk = ~clk;
   medc_detect i_dut (.clk(clk), .rst_b(rst_b), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
      .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_ack_o(wb_ack_o), .sample_stb(sample_stb), .sample(sample),
      .emb_func_evt(emb_func_evt), .shub_done_evt(shub_done_evt),
      .irq_pin_one(irq_pin_one), .irq_o(irq_o), .sleep_state(sleep_state));
   medc_host i_host (.clk(clk), .wb_ack_o(wb_ack_o), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i));
   // ****************
   // Helpers
   // ****************
   task automatic end_sim();
      $display("errors %0d compares %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      i_host.xfer(a, 1'b1, v);
   endtask
   // Expected data noted before the cycle starts
   task automatic rd(input logic [7:0] a, input logic [7:0] v);
      exp_q.push_back({24'h00_0000, v});
      i_host.xfer(a, 1'b0, 8'h00);
   endtask
   // Output read after the wait: 0 irq, 1 pin one, 2 sleep
   task automatic chk(input int b, input logic want);
      repeat (3) @(posedge clk);
      cmp_count++;
      if (outs[b] !== want) begin
         err_count++;
         $display("ERROR %0t output %0d level %b not %b", $time, b,
            outs[b], want);
      end
   endtask
   // Samples spaced apart; total near 1 g keeps free-fall quiet
   task automatic smp(input logic [7:0] hp, input logic [7:0] lp,
                      input logic [7:0] tz, input int n);
      repeat (n) begin
         @(posedge clk);
         sample_stb <= 1'b1;
         sample <= '{tap_z_mag: tz, wake_hp_mag: hp, wake_lp_mag: lp,
            total_mag: 8'hff, default: 8'h00};
         @(posedge clk);
         sample_stb <= 1'b0;
         repeat (2) @(posedge clk);
      end
   endtask
   // Read data is taken at the edge where ack is seen
   always @(posedge clk) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
         cmp_count++;
         if (exp_q.size() == 0 || wb_dat_o !== exp_q[0]) begin
            err_count++;
            $display("ERROR %0t read data %h", $time, wb_dat_o);
         end
         if (exp_q.size() > 0) void'(exp_q.pop_front());
      end
   end
   // Hang guard, well above the expected run length
   always @(posedge clk) begin
      cyc_n++;
      if (cyc_n > 20000) begin
         err_count++;
         end_sim();
      end
   end
   // ****************
   // Main sequence
   // ****************
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      foreach (rst_idx[i]) rd(rst_idx[i], 8'h00);
      for (int i = 0; i < 6; i++) begin
         d = $random(seed);
         wr(8'h59 + i, d);
         rd(8'h59 + i, d);
      end
      rd(8'h10, 8'h00);
      wr(medc_pkg::IDX_EVT_STATUS, 8'hff);
      wr(medc_pkg::IDX_ROUTE1, 8'h00);
      wr(medc_pkg::IDX_EVT_CLEAR, 8'hff);
      rd(medc_pkg::IDX_EVT_STATUS, 8'h00);
      rd(medc_pkg::IDX_EVT_CLEAR, 8'h00);
      // Interrupt raised masked, enabled, routed, cleared
      @(posedge clk) emb_func_evt <= 1'b1;
      shub_done_evt <= 1'b1;
      @(posedge clk) emb_func_evt <= 1'b0;
      shub_done_evt <= 1'b0;
      rd(medc_pkg::IDX_EVT_STATUS, 8'h03);
      chk(0, 1'b0);
      chk(1, 1'b0);
      wr(medc_pkg::IDX_EVT_ENABLE, 8'h02);
      chk(0, 1'b1);
      wr(medc_pkg::IDX_ROUTE1, 8'h03);
      chk(1, 1'b1);
      wr(medc_pkg::IDX_EVT_CLEAR, 8'h03);
      chk(0, 1'b0);
      chk(1, 1'b0);
      // A fresh routed event reaches the pin again
      @(posedge clk) emb_func_evt <= 1'b1;
      @(posedge clk) emb_func_evt <= 1'b0;
      chk(1, 1'b1);
      wr(medc_pkg::IDX_EVT_CLEAR, 8'h02);
      chk(1, 1'b0);
      // Wake: level 8 of 64ths is 32, persist 2, sleep code 0
      wr(medc_pkg::IDX_ORIENT_TAP, 8'h00);
      wr(medc_pkg::IDX_TAP_WIN, 8'h00);
      wr(medc_pkg::IDX_WAKE_THS, 8'h08);
      wr(medc_pkg::IDX_WAKEUP_PERSIST_COUNT, 8'h40);
      wr(medc_pkg::IDX_BASIC_CTRL, 8'h00);
      smp(8'd40, 8'd0, 8'd0, 4);
      rd(medc_pkg::IDX_EVT_STATUS, 8'h00);
      wr(medc_pkg::IDX_BASIC_CTRL, 8'h01);
      smp(8'd16, 8'd0, 8'd0, 4);
      rd(medc_pkg::IDX_EVT_STATUS, 8'h00);
      smp(8'd40, 8'd0, 8'd0, 2);
      rd(medc_pkg::IDX_EVT_STATUS, 8'h00);
      smp(8'd40, 8'd0, 8'd0, 1);
      rd(medc_pkg::IDX_EVT_STATUS, 8'h20);
      // Low-pass source ignores the high-pass level
      wr(medc_pkg::IDX_EVT_CLEAR, 8'hff);
      wr(medc_pkg::IDX_WAKE_THS, 8'h48);
      smp(8'd40, 8'd0, 8'd0, 4);
      rd(medc_pkg::IDX_EVT_STATUS, 8'h00);
      // Sleep after 16 quiet samples for code 0
      wr(medc_pkg::IDX_WAKE_THS, 8'h08);
      wr(medc_pkg::IDX_EVT_ENABLE, 8'h80);
      smp(8'd40, 8'd0, 8'd0, 1);
      smp(8'd0, 8'd0, 8'd0, 15);
      chk(2, 1'b0);
      smp(8'd0, 8'd0, 8'd0, 1);
      chk(2, 1'b1);
      chk(0, 1'b1);
      // Tap: Z level 4 of 32nds is 32, shock limit 4 samples
      wr(medc_pkg::IDX_ORIENT_TAP, 8'h04);
      wr(medc_pkg::IDX_EVT_CLEAR, 8'hff);
      smp(8'd0, 8'd0, 8'd40, 6);
      smp(8'd0, 8'd0, 8'd0, 4);
      rd(medc_pkg::IDX_EVT_STATUS, 8'h00);
      smp(8'd0, 8'd0, 8'd40, 2);
      smp(8'd0, 8'd0, 8'd0, 4);
      rd(medc_pkg::IDX_EVT_STATUS, 8'h40);
      // Second pulse inside the gap adds the double event
      wr(medc_pkg::IDX_WAKE_THS, 8'h88);
      wr(medc_pkg::IDX_EVT_CLEAR, 8'hff);
      smp(8'd0, 8'd0, 8'd40, 2);
      smp(8'd0, 8'd0, 8'd0, 4);
      smp(8'd0, 8'd0, 8'd40, 2);
      smp(8'd0, 8'd0, 8'd0, 4);
      rd(medc_pkg::IDX_EVT_STATUS, 8'h48);
      end_sim();
   end
endmodule // medc_detect_bench
